// File: common/sebi_params.svh
/*
  Constants for the serial memory bus front end: memory geometry, instruction codes,
  status register bit positions. Assumes inclusion by design files only.
*/
`ifndef SEBI_PARAMS_SVH
`define SEBI_PARAMS_SVH

`define SEBI_MEM_DEPTH      2048
`define SEBI_MEM_DEPTH_SML  1024
`define SEBI_ADDR_W         11
`define SEBI_BYTE_W         8
`define SEBI_OP_WREN        8'h06
`define SEBI_OP_WRDI        8'h04
`define SEBI_OP_RDSR        8'h05
`define SEBI_OP_WRSR        8'h01
`define SEBI_OP_READ        8'h03
`define SEBI_OP_WRITE       8'h02
`define SEBI_BP_LO_BIT      2
`define SEBI_BP_HI_BIT      3
`define SEBI_SRWD_BIT       7
`define SEBI_WEL_BIT        1
`define SEBI_PAGE_W         5

`endif

// File: common/sebi_pkg.sv
/*
  Types for the serial memory bus front end.
  Assumes sebi_params.svh is available to design files.
*/
package sebi_pkg;

  typedef enum logic [4:0] {
    SEBI_IDLE  = 5'h01,
    SEBI_OPC   = 5'h02,
    SEBI_ADDR  = 5'h04,
    SEBI_DATA  = 5'h08,
    SEBI_DEAD  = 5'h10
  } sebi_state_t;

endpackage : sebi_pkg

// File: design/sebi_sync.sv
/*
  Two flip-flop synchroniser for a vector of pins.
  Assumes the inputs are asynchronous to clk_i.
*/
`timescale 1ns/1ps
module sebi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] init_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= init_i;
      sync_o <= init_i;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : sebi_sync

// File: design/sebi_bus_if.sv
/*
  Serial bus target front end of a byte-organised nonvolatile memory, with its array,
  block-protect bits and write-protect lock. Assumes pins are asynchronous to clk_i,
  the serial clock is sampled, and rst_i stands for the power-on reset.
*/
`timescale 1ns/1ps
`include "sebi_params.svh"
module sebi_bus_if #(
  parameter int DEPTH = `SEBI_MEM_DEPTH
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sclk_i,
  input  wire logic sdi_i,
  input  wire logic sel_n_i,
  input  wire logic pause_n_i,
  input  wire logic wprot_n_i,
  output logic      sdo_o,
  output logic      sdo_oe_o,
  output logic      active_o,
  output logic      paused_o,
  output logic      block_protect_hi_o,
  output logic      block_protect_lo_o
);

  localparam int AW = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] pins_s;
  // select starts low: a select already low at release never counts as a fall
  sebi_sync #(.W(5)) sebi_sync_i (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .init_i  (5'h03),
    .async_i ({sclk_i, sdi_i, sel_n_i, pause_n_i, wprot_n_i}),
    .sync_o  (pins_s)
  );
  wire sclk_s  = pins_s[4];
  wire sdi_s   = pins_s[3];
  wire seln_s  = pins_s[2];
  wire pausn_s = pins_s[1];
  wire wpn_s   = pins_s[0];

  logic sclk_q;
  logic seln_q;
  logic pausn_q;
  wire  sck_rise = sclk_s & ~sclk_q;
  wire  sck_fall = ~sclk_s & sclk_q;
  wire  sel_fall = ~seln_s & seln_q;
  wire  sel_rise = seln_s & ~seln_q;

  ////////////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]            mem_q [DEPTH];
  sebi_pkg::sebi_state_t st_q;
  logic                  armed_q;
  logic                  paused_q;
  logic [2:0]            bitc_q;
  logic [7:0]            shin_q;
  logic [7:0]            shout_q;
  logic [7:0]            opc_q;
  logic [15:0]           addr_q;
  logic                  abyte_q;
  logic [7:0]            wbuf_q;
  logic                  wpend_q;
  logic                  wel_q;
  logic                  srwd_q;
  logic [1:0]            bp_q;
  logic                  rd_mode_q;
  logic                  sdo_q;
  logic                  oe_q;

  function automatic logic prot_hit(input logic [1:0] bp, input logic [AW-1:0] a);
    logic [1:0] top;
    top = a[AW-1 -: 2];
    case (bp)
      2'h1:    prot_hit = (top == 2'h3);
      2'h2:    prot_hit = top[1];
      2'h3:    prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  endfunction : prot_hit

  wire        selected  = ~seln_s & armed_q;
  wire        bit_take  = selected & ~paused_q & sck_rise;
  wire        bit_shift = selected & ~paused_q & sck_fall;
  wire [7:0]  byte_in   = {shin_q[6:0], sdi_s};
  wire        byte_done = bit_take & (bitc_q == 3'h7);
  wire [AW-1:0] aidx    = addr_q[AW-1:0];
  wire        is_read   = (opc_q == `SEBI_OP_READ) | (opc_q == `SEBI_OP_RDSR);
  wire [7:0]  status_w  = {srwd_q, 3'h0, bp_q, wel_q, 1'b0};
  wire        sr_lock   = srwd_q & ~wpn_s;
  // entry and exit only with the serial clock low
  wire        pause_on  = selected & ~paused_q & ~pausn_s & pausn_q & ~sclk_s;
  wire        pause_off = paused_q & pausn_s & ~pausn_q & ~sclk_s;

  ////////////////////////////////////////////////////////////////////////////////////
  // edge history and power-up arming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q  <= 1'b0;
      seln_q  <= 1'b0;
      pausn_q <= 1'b1;
      armed_q <= 1'b0;
    end else begin
      sclk_q  <= sclk_s;
      seln_q  <= seln_s;
      pausn_q <= pausn_s;
      if (sel_fall)
        armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      paused_q <= 1'b0;
    else if (seln_s)
      paused_q <= 1'b0;
    else if (pause_on)
      paused_q <= 1'b1;
    else if (pause_off)
      paused_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // receive path and command sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i || seln_s) begin
      bitc_q    <= 3'h0;
      shin_q    <= 8'h00;
      st_q      <= sebi_pkg::SEBI_IDLE;
      abyte_q   <= 1'b0;
      rd_mode_q <= 1'b0;
    end else if (bit_take) begin
      bitc_q <= bitc_q + 3'h1;
      shin_q <= byte_in;
      if (byte_done) begin
        case (st_q)
          sebi_pkg::SEBI_IDLE, sebi_pkg::SEBI_OPC: begin
            opc_q <= byte_in;
            if (byte_in == `SEBI_OP_READ || byte_in == `SEBI_OP_WRITE)
              st_q <= sebi_pkg::SEBI_ADDR;
            else if (byte_in == `SEBI_OP_RDSR) begin
              st_q      <= sebi_pkg::SEBI_DATA;
              rd_mode_q <= 1'b1;
            end else if (byte_in == `SEBI_OP_WRSR)
              st_q <= sebi_pkg::SEBI_DATA;
            else
              st_q <= sebi_pkg::SEBI_DEAD;
          end
          sebi_pkg::SEBI_ADDR: begin
            addr_q  <= {addr_q[7:0], byte_in};
            abyte_q <= 1'b1;
            if (abyte_q) begin
              st_q      <= sebi_pkg::SEBI_DATA;
              rd_mode_q <= (opc_q == `SEBI_OP_READ);
            end
          end
          sebi_pkg::SEBI_DATA: begin
            if (opc_q == `SEBI_OP_READ)
              addr_q <= addr_q + 16'h0001;
          end
          default: st_q <= sebi_pkg::SEBI_DEAD;
        endcase
      end
    end else if (st_q == sebi_pkg::SEBI_IDLE)
      st_q <= sebi_pkg::SEBI_OPC;
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // write capture; commits only on a byte-aligned deselect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wpend_q <= 1'b0;
      wel_q   <= 1'b0;
      srwd_q  <= 1'b0;
      bp_q    <= 2'h0;
      wbuf_q  <= 8'h00;
    end else begin
      if (byte_done && st_q == sebi_pkg::SEBI_DATA && !is_read) begin
        wbuf_q  <= byte_in;
        wpend_q <= 1'b1;
      end else if (bit_take)
        wpend_q <= 1'b0;
      if (byte_done && st_q != sebi_pkg::SEBI_DATA && st_q != sebi_pkg::SEBI_ADDR) begin
        if (byte_in == `SEBI_OP_WREN)
          wel_q <= 1'b1;
        else if (byte_in == `SEBI_OP_WRDI)
          wel_q <= 1'b0;
      end
      // commit happens on deselect only when not paused; a deselect while paused drops it
      if (sel_rise && wpend_q && wel_q && !paused_q) begin
        wpend_q <= 1'b0;
        wel_q   <= 1'b0;
        if (opc_q == `SEBI_OP_WRSR) begin
          if (!sr_lock) begin
            bp_q   <= wbuf_q[`SEBI_BP_HI_BIT:`SEBI_BP_LO_BIT];
            srwd_q <= wbuf_q[`SEBI_SRWD_BIT];
          end
        end else if (!prot_hit(bp_q, aidx))
          mem_q[aidx] <= wbuf_q;
      end else if (sel_rise)
        wpend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // transmit path
  always_ff @(posedge clk_i) begin
    if (rst_i || seln_s) begin
      shout_q <= 8'h00;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else if (bit_shift) begin
      if (rd_mode_q) begin
        oe_q <= 1'b1;
        if (bitc_q == 3'h0) begin
          sdo_q   <= (opc_q == `SEBI_OP_RDSR) ? status_w[7] : mem_q[aidx][7];
          shout_q <= (opc_q == `SEBI_OP_RDSR) ? {status_w[6:0], 1'b0}
                                               : {mem_q[aidx][6:0], 1'b0};
        end else begin
          sdo_q   <= shout_q[7];
          shout_q <= {shout_q[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_o              <= 1'b0;
      sdo_oe_o           <= 1'b0;
      active_o           <= 1'b0;
      paused_o           <= 1'b0;
      block_protect_hi_o <= 1'b0;
      block_protect_lo_o <= 1'b0;
    end else begin
      sdo_o              <= sdo_q;
      sdo_oe_o           <= oe_q & ~paused_q & ~seln_s;
      active_o           <= selected | wpend_q;
      paused_o           <= paused_q;
      block_protect_hi_o <= bp_q[1];
      block_protect_lo_o <= bp_q[0];
    end
  end

endmodule : sebi_bus_if

// File: bench/sebi_bus_if_monitor.sv
/* Checker bound to the sebi_bus_if ports.
   Assumes clk_i sees every pin edge; raw pins lead the synchronised view. */
`timescale 1ns/1ps
module sebi_bus_if_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic pause_n_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic active_o,
  input wire logic paused_o
);
  logic       sclk_q, sel_q, arm_q;
  logic [3:0] age_q;
  logic [4:0] nfall_q;
  wire        fall_w = sclk_q && !sclk_i;
  // bounds below allow for the design's sync lag behind the raw pins
  always_ff @(posedge clk_i) begin
    sclk_q  <= sclk_i;
    sel_q   <= sel_n_i;
    arm_q   <= !rst_i && (arm_q || (sel_q && !sel_n_i));
    age_q   <= fall_w ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
    nfall_q <= sel_n_i ? 5'h00 : nfall_q + {4'h0, fall_w && nfall_q != 5'h1F};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  property p_desel; sel_n_i [*6] |-> !sdo_oe_o; endproperty
  a_desel: assert property (p_desel) else $error("driving while deselected");
  property p_hold_oe; paused_o [*6] |-> !sdo_oe_o; endproperty
  a_hold_oe: assert property (p_hold_oe) else $error("driving while paused");
  property p_shift; sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o) |-> age_q < 4'h8; endproperty
  a_shift: assert property (p_shift) else $error("data moved off a falling edge");
  property p_first; $rose(sdo_oe_o) && !$past(paused_o, 8) |-> age_q < 4'h8; endproperty
  a_first: assert property (p_first) else $error("first bit not after a fall");
  property p_late; $rose(sdo_oe_o) |-> !sel_n_i && nfall_q >= 5'h08; endproperty
  a_late: assert property (p_late) else $error("driving during command bits");
  property p_arm; !arm_q |-> !active_o && !sdo_oe_o; endproperty
  a_arm: assert property (p_arm) else $error("active before a select fall");
  property p_hold_in; $rose(paused_o) |-> !sel_n_i && !pause_n_i && !sclk_i; endproperty
  a_hold_in: assert property (p_hold_in) else $error("bad pause entry");
  property p_hold_out; $fell(paused_o) |-> sel_n_i || (pause_n_i && !sclk_i); endproperty
  a_hold_out: assert property (p_hold_out) else $error("bad pause exit");
endmodule : sebi_bus_if_chk
bind sebi_bus_if sebi_bus_if_chk sebi_bus_if_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .sclk_i(sclk_i), .sel_n_i(sel_n_i), .pause_n_i(pause_n_i), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o), .active_o(active_o), .paused_o(paused_o));

// File: bench/sebi_master.sv
/* Serial bus master model: clock idles low, 80 ns half period.
   Assumes clk_i is the bench clock; pins move 1 ns after its edge. */
`timescale 1ns/1ps
module sebi_master (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      sdi_o,
  output logic      sel_n_o,
  output logic      pause_n_o,
  output logic      wprot_n_o
);
  initial begin
    sclk_o    = 1'b0;
    sdi_o     = 1'b0;
    sel_n_o   = 1'b1;
    pause_n_o = 1'b1;
    wprot_n_o = 1'b1;
  end
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // sample just before the rise; the target only moves after falls
  task automatic pulse(output logic s);
    tick(8);
    s = sdo_i;
    sclk_o = 1'b1;
    tick(8);
    sclk_o = 1'b0;
  endtask : pulse
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sdi_o = d[i];
      pulse(q[i]);
    end
  endtask : xbyte
  // select or pause pin, only moved with the clock low
  task automatic frame(input bit hold, input logic v);
    tick(8);
    if (hold) pause_n_o = v;
    else sel_n_o = v;
    tick(8);
  endtask : frame
endmodule : sebi_master

// File: bench/test_sebi_bus_if.sv
/* Self-checking bench for sebi_bus_if driven by the sebi_master model.
   Assumes the model and the bound checker are compiled before it. */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: mismatch", $time); end end
module test_sebi_bus_if;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       last_q = 1'b0;
  logic [7:0] q;
  int         fails = 0;
  int         tests_run = 0;
  wire        sclk, sdi, sel_n, pause_n, wprot_n, sdo, sdo_oe, active, paused, bp_hi, bp_lo;
  // a released data line shows the inverse of its last level
  wire        sdo_w = sdo_oe ? sdo : ~last_q;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (sdo_oe) last_q <= sdo;
  sebi_bus_if sebi_bus_if_i (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .sdi_i(sdi),
    .sel_n_i(sel_n), .pause_n_i(pause_n), .wprot_n_i(wprot_n), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .active_o(active), .paused_o(paused), .block_protect_hi_o(bp_hi), .block_protect_lo_o(bp_lo));
  sebi_master sebi_master_i (.clk_i(clk_i), .sdo_i(sdo_w), .sclk_o(sclk), .sdi_o(sdi),
    .sel_n_o(sel_n), .pause_n_o(pause_n), .wprot_n_o(wprot_n));
  ////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic wait_hold(input logic v);
    int k;
    for (k = 0; k < 40 && paused !== v; k++) #10;
    if (k == 40) begin
      fails++;
      test_done();
    end
  endtask : wait_hold
  task automatic tx(input logic [31:0] b, input int n, input bit ext = 1'b0);
    sebi_master_i.frame(1'b0, 1'b0);
    for (int i = 0; i < n; i++) sebi_master_i.xbyte(b[31-8*i -: 8], q);
    if (ext) sebi_master_i.pulse(q[0]);
    sebi_master_i.frame(1'b0, 1'b1);
  endtask : tx
  task automatic t_rw();
    tx(32'h0600_0000, 1);
    tx(32'h0207_FFA5, 4);
    tx(32'h0600_0000, 1);
    tx(32'h0200_005A, 4);
    tx(32'h0207_FF3C, 4); // no write enable, refused
    tx(32'h0600_0000, 1);
    tx(32'h0207_FF3C, 4, 1'b1); // nine clocks in the last byte, refused
    tx(32'h0307_FF00, 4);
    `CHK(q, 8'hA5)
    tx(32'h0300_0000, 4);
    `CHK(q, 8'h5A)
    tx(32'h0400_0000, 1);
    tx(32'h0500_0000, 2);
    `CHK(q, 8'h00)
    $display("t_rw end");
  endtask : t_rw
  task automatic t_hold();
    sebi_master_i.frame(1'b0, 1'b0);
    sebi_master_i.xbyte(8'h03, q);
    `CHK(active, 1'b1)
    sebi_master_i.xbyte(8'h07, q);
    sebi_master_i.xbyte(8'hFF, q);
    sebi_master_i.frame(1'b1, 1'b0);
    wait_hold(1'b1);
    sebi_master_i.pulse(q[0]);
    `CHK(sdo_oe, 1'b0)
    sebi_master_i.frame(1'b1, 1'b1);
    wait_hold(1'b0);
    sebi_master_i.xbyte(8'h00, q);
    sebi_master_i.frame(1'b0, 1'b1);
    `CHK(q, 8'hA5)
    `CHK(active, 1'b0)
    // complete write byte, then deselect while paused: must be dropped
    tx(32'h0600_0000, 1);
    sebi_master_i.frame(1'b0, 1'b0);
    sebi_master_i.xbyte(8'h02, q);
    sebi_master_i.xbyte(8'h07, q);
    sebi_master_i.xbyte(8'hFF, q);
    sebi_master_i.xbyte(8'h3C, q);
    sebi_master_i.frame(1'b1, 1'b0);
    wait_hold(1'b1);
    sebi_master_i.frame(1'b0, 1'b1);
    `CHK(paused, 1'b0)
    sebi_master_i.frame(1'b1, 1'b1);
    sebi_master_i.frame(1'b1, 1'b0);
    `CHK(paused, 1'b0)
    sebi_master_i.frame(1'b1, 1'b1);
    tx(32'h0307_FF00, 4);
    `CHK(q, 8'hA5)
    $display("t_hold end");
  endtask : t_hold
  task automatic t_protect();
    tx(32'h0600_0000, 1);
    tx(32'h018C_0000, 2);
    tx(32'h0500_0000, 2);
    `CHK(q, 8'h8C)
    `CHK({bp_hi, bp_lo}, 2'h3)
    sebi_master_i.wprot_n_o = 1'b0;
    tx(32'h0600_0000, 1);
    tx(32'h0100_0000, 2);
    `CHK({bp_hi, bp_lo}, 2'h3)
    sebi_master_i.wprot_n_o = 1'b1;
    tx(32'h0600_0000, 1);
    tx(32'h0100_0000, 2);
    `CHK({bp_hi, bp_lo}, 2'h0)
    $display("t_protect end");
  endtask : t_protect
  // reset with select already low: a full read must be ignored until reselect
  task automatic t_arm();
    sebi_master_i.frame(1'b0, 1'b0);
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    sebi_master_i.xbyte(8'h03, q);
    sebi_master_i.xbyte(8'h07, q);
    sebi_master_i.xbyte(8'hFF, q);
    sebi_master_i.xbyte(8'h00, q);
    `CHK(active, 1'b0)
    `CHK(sdo_oe, 1'b0)
    sebi_master_i.frame(1'b0, 1'b1);
    tx(32'h0307_FF00, 4);
    `CHK(q, 8'hA5)
    $display("t_arm end");
  endtask : t_arm
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_rw();
    t_hold();
    t_protect();
    t_arm();
    test_done();
  end
endmodule : test_sebi_bus_if
